// file: verilog/sfq_flash_seq.sv
// Purpose: Quad read, page program, sector and block erase front end of a serial NOR flash.
// Assumes: ref_clk runs at least eight times the serial clock; memRdData follows memRdAddr next cycle.
// Notes: All pins pass a two-flop synchroniser, so answers lag the pin edges by a few ref_clk cycles.
`timescale 1ns/100ps
`include "sfq_consts.svh"

module sfq_fifo #(
   parameter int WIDTH = 41,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];  // Storage, no reset needed
   logic [AW:0] wrPtr_q;  // Extra bit tells full from empty
   logic [AW:0] rdPtr_q;

   assign inReady = (wrPtr_q - rdPtr_q) != (AW + 1)'(DEPTH);
   assign outValid = wrPtr_q != rdPtr_q;
   assign outData = mem[rdPtr_q[AW-1:0]];

   // Entry write
   always_ff @(posedge clk) begin
      if (inValid && inReady) begin
         mem[wrPtr_q[AW-1:0]] <= inData;
      end
   end

   // Pointers
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (inValid && inReady) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (outValid && outReady) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end
endmodule

module sfq_flash_seq #(
   parameter int ADDR_W = 25,
   parameter int FIFO_DEPTH = 8,
   parameter int PROG_CYC = `SFQ_PROG_TIME_US * `SFQ_CLK_MHZ,
   parameter int SECT_CYC = `SFQ_SECT_TIME_US * `SFQ_CLK_MHZ,
   parameter int BLK_CYC = `SFQ_BLK_TIME_US * `SFQ_CLK_MHZ
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic sclkPin,
   input wire logic csPin_n,
   input wire logic [3:0] ioLineIn,
   output logic [3:0] ioLineOut,
   output logic [3:0] ioLineOe_n,
   input wire logic fourByteMode,
   input wire logic quadCommandMode,
   input wire logic [3:0] blockProtectBits,
   output logic writeEnableLatch,
   output logic writeInProgressFlag,
   output logic executeInPlace,
   output logic [31:0] memRdAddr,
   input wire logic [7:0] memRdData,
   output logic memWrValid,
   input wire logic memWrReady,
   output sfq_pkg::sfqProgWord_t memWr,
   output logic eraseStrobe,
   output sfq_pkg::sfqErase_t eraseReq
);
   if (ADDR_W < 17 || ADDR_W > 32 || BLK_CYC >= (1 << 27) || PROG_CYC < 1) begin : g_chk
      $error("sequencer parameters out of range");
   end
   localparam logic [31:0] ADDR_MASK = 32'((64'h1 << ADDR_W) - 64'h1);

   logic [5:0] pinS1_q;  // First sync stage, read only by pinS2_q
   logic [5:0] pinS2_q;  // {io[3:0], csN, sclk}
   logic sclkS3_q;
   logic csS3_q;
   logic sclkRise, sclkFall, csLow, csFall, csRise;
   logic [3:0] io;
   sfq_pkg::sfqProto_t state_q;
   sfq_pkg::sfqBusy_t busySt_q;
   logic [5:0] cnt_q;  // Clocks within the current phase
   logic [5:0] cntNext, phaseClks, bits;
   logic [31:0] sh_q;  // Input shifter
   logic [31:0] shNext, addrVal;
   logic [7:0] opc_q;
   logic [31:0] cmdAddr_q;  // Address of program or erase
   logic rdCmd_q;  // Transfer is a quad read
   logic wide, phaseEnd, addrDone, pbWr;
   logic [7:0] modeByte_q;
   logic modeSeen_q;
   logic modeInv;
   logic contMode_q;  // Continuous read: next select skips the opcode
   logic weLatch_q, busy_q;
   logic [31:0] rdAddr_q;
   logic nibHi_q;  // Next falling edge drives the high nibble
   logic [3:0] ioOut_q, ioOeN_q;
   logic [7:0] pageBuf [256];  // Latched program data
   logic [255:0] pbMask_q;  // Bytes of the page that were sent
   logic [7:0] pbOff_q;
   logic pbAny_q;
   logic [7:0] scanIdx_q;
   logic [26:0] timer_q;
   logic protHit, startProg, startErase, drainPush, fifoInReady;
   logic eraseStrobe_q;
   sfq_pkg::sfqErase_t eraseReq_q;
   sfq_pkg::sfqProgWord_t drainWord;

   // Region guard: bp=n protects the top 2^(n-1) blocks
   function automatic logic isProt(input logic [31:0] a, input logic [3:0] bp);
      logic [31:0] top;
      top = 32'h1 << (ADDR_W - `SFQ_BLOCK_BITS);
      return (bp != 4'h0) && ((a >> `SFQ_BLOCK_BITS) + (32'h1 << (bp - 4'h1)) >= top);
   endfunction

   // Pin synchroniser and edge detectors
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pinS1_q <= `SFQ_PIN_RST;
         pinS2_q <= `SFQ_PIN_RST;
         sclkS3_q <= 1'b0;
         csS3_q <= 1'b1;
      end else begin
         pinS1_q <= {ioLineIn, csPin_n, sclkPin};
         pinS2_q <= pinS1_q;
         sclkS3_q <= pinS2_q[0];
         csS3_q <= pinS2_q[1];
      end
   end
   assign sclkRise = pinS2_q[0] && !sclkS3_q;
   assign sclkFall = !pinS2_q[0] && sclkS3_q;
   assign csLow = !pinS2_q[1];
   assign csFall = !pinS2_q[1] && csS3_q;
   assign csRise = pinS2_q[1] && !csS3_q;
   assign io = pinS2_q[5:2];

   // Phase length and shifter next value
   always_comb begin
      wide = rdCmd_q || quadCommandMode;
      bits = `SFQ_BYTE_BITS;
      if (state_q == sfq_pkg::S_ADDR) begin
         bits = fourByteMode ? `SFQ_ADDR4_BITS : `SFQ_ADDR3_BITS;
      end
      phaseClks = wide ? {2'h0, bits[5:2]} : bits;
      cntNext = cnt_q + 6'h01;
      phaseEnd = cntNext == phaseClks;
      shNext = wide ? {sh_q[27:0], io} : {sh_q[30:0], io[0]};
      addrVal = (fourByteMode ? shNext : {8'h00, shNext[23:0]}) & ADDR_MASK;
   end
   assign addrDone = sclkRise && csLow && state_q == sfq_pkg::S_ADDR && phaseEnd;
   assign pbWr = sclkRise && csLow && state_q == sfq_pkg::S_PDAT && phaseEnd;
   assign modeInv = modeByte_q[7:4] == ~modeByte_q[3:0];

   // Serial protocol state
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q <= sfq_pkg::S_IDLE;
         cnt_q <= 6'h00;
         sh_q <= 32'h0;
         opc_q <= 8'h00;
         cmdAddr_q <= 32'h0;
         rdCmd_q <= 1'b0;
         modeByte_q <= 8'h00;
         modeSeen_q <= 1'b0;
         contMode_q <= 1'b0;
      end else if (csFall) begin
         cnt_q <= 6'h00;
         rdCmd_q <= contMode_q;
         modeSeen_q <= 1'b0;
         if (!contMode_q) begin
            state_q <= sfq_pkg::S_OPC;
         end else if (busy_q) begin
            state_q <= sfq_pkg::S_IGN;
         end else begin
            // Continuous mode starts straight at the address
            opc_q <= `SFQ_OP_QREAD;
            state_q <= sfq_pkg::S_ADDR;
         end
      end else if (!csLow) begin
         state_q <= sfq_pkg::S_IDLE;
         // Only a completed mode byte may change the continuous mode
         if (csRise && rdCmd_q && modeSeen_q) begin
            contMode_q <= modeInv;
         end
      end else if (sclkRise) begin
         sh_q <= shNext;
         cnt_q <= cntNext;
         case (state_q)
            sfq_pkg::S_OPC: begin
               if (phaseEnd) begin
                  cnt_q <= 6'h00;
                  opc_q <= shNext[7:0];
                  case (shNext[7:0])
                     `SFQ_OP_QREAD: begin
                        rdCmd_q <= 1'b1;
                        state_q <= busy_q ? sfq_pkg::S_IGN : sfq_pkg::S_ADDR;
                     end
                     `SFQ_OP_WEN: begin
                        state_q <= sfq_pkg::S_WEN;
                     end
                     `SFQ_OP_PROG, `SFQ_OP_SECT, `SFQ_OP_BLOCK: begin
                        // Latch must be set and no cycle running
                        state_q <= (weLatch_q && !busy_q) ? sfq_pkg::S_ADDR : sfq_pkg::S_IGN;
                     end
                     default: begin
                        state_q <= sfq_pkg::S_IGN;
                     end
                  endcase
               end
            end
            sfq_pkg::S_ADDR: begin
               if (phaseEnd) begin
                  cnt_q <= 6'h00;
                  cmdAddr_q <= addrVal;
                  if (rdCmd_q) begin
                     state_q <= sfq_pkg::S_MODE;
                  end else if (opc_q == `SFQ_OP_PROG) begin
                     state_q <= sfq_pkg::S_PDAT;
                  end else begin
                     state_q <= sfq_pkg::S_EWAIT;
                  end
               end
            end
            sfq_pkg::S_MODE: begin
               if (cntNext == `SFQ_MODE_CLKS) begin
                  cnt_q <= 6'h00;
                  modeByte_q <= shNext[7:0];
                  modeSeen_q <= 1'b1;
                  state_q <= sfq_pkg::S_DUMMY;
               end
            end
            sfq_pkg::S_DUMMY: begin
               if (cntNext == `SFQ_DUMMY_CLKS) begin
                  cnt_q <= 6'h00;
                  state_q <= sfq_pkg::S_DATA;
               end
            end
            sfq_pkg::S_PDAT: begin
               if (phaseEnd) begin
                  cnt_q <= 6'h00;
               end
            end
            sfq_pkg::S_EWAIT, sfq_pkg::S_WEN: begin
               // Any extra clock spoils an erase or latch set
               state_q <= sfq_pkg::S_IGN;
            end
            default: begin
               state_q <= state_q;
            end
         endcase
      end
   end

   // Read data driver; lines released as soon as select rises
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ioOut_q <= 4'h0;
         ioOeN_q <= `SFQ_OE_OFF;
         nibHi_q <= 1'b1;
         rdAddr_q <= 32'h0;
      end else begin
         if (addrDone && rdCmd_q) begin
            rdAddr_q <= addrVal;
         end
         if (!csLow || state_q != sfq_pkg::S_DATA) begin
            ioOeN_q <= `SFQ_OE_OFF;
            nibHi_q <= 1'b1;
         end else if (sclkFall) begin
            ioOeN_q <= 4'h0;
            ioOut_q <= nibHi_q ? memRdData[7:4] : memRdData[3:0];
            nibHi_q <= !nibHi_q;
            if (!nibHi_q) begin
               rdAddr_q <= (rdAddr_q + 32'h1) & ADDR_MASK;
            end
         end
      end
   end

   // Page buffer data; the offset wraps inside the page
   always_ff @(posedge ref_clk) begin
      if (pbWr) begin
         pageBuf[pbOff_q] <= shNext[7:0];
      end
   end

   // Page buffer bookkeeping
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pbMask_q <= '0;
         pbOff_q <= 8'h00;
         pbAny_q <= 1'b0;
      end else if (addrDone && !rdCmd_q && opc_q == `SFQ_OP_PROG) begin
         pbMask_q <= '0;
         pbOff_q <= addrVal[7:0];
         pbAny_q <= 1'b0;
      end else if (pbWr) begin
         // Later bytes overwrite earlier ones, unsent bytes stay unmasked
         pbMask_q[pbOff_q] <= 1'b1;
         pbOff_q <= pbOff_q + 8'h01;
         pbAny_q <= 1'b1;
      end
   end

   assign protHit = isProt(cmdAddr_q, blockProtectBits);
   assign startProg = csRise && state_q == sfq_pkg::S_PDAT && cnt_q == 6'h00 && pbAny_q && !protHit;
   assign startErase = csRise && state_q == sfq_pkg::S_EWAIT && !protHit;
   assign drainPush = busySt_q == sfq_pkg::B_DRAIN && pbMask_q[scanIdx_q];
   assign drainWord.addr = {cmdAddr_q[31:`SFQ_PAGE_BITS], scanIdx_q};
   assign drainWord.data = pageBuf[scanIdx_q];

   // Self-timed cycle, latch and busy flag
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busySt_q <= sfq_pkg::B_IDLE;
         weLatch_q <= 1'b0;
         busy_q <= 1'b0;
         scanIdx_q <= 8'h00;
         timer_q <= 27'h0;
         eraseStrobe_q <= 1'b0;
         eraseReq_q <= '0;
      end else begin
         eraseStrobe_q <= 1'b0;
         case (busySt_q)
            sfq_pkg::B_IDLE: begin
               if (startProg) begin
                  busy_q <= 1'b1;
                  weLatch_q <= 1'b0;
                  scanIdx_q <= 8'h00;
                  timer_q <= 27'(PROG_CYC);
                  busySt_q <= sfq_pkg::B_DRAIN;
               end else if (startErase) begin
                  busy_q <= 1'b1;
                  weLatch_q <= 1'b0;
                  eraseStrobe_q <= 1'b1;
                  if (opc_q == `SFQ_OP_BLOCK) begin
                     eraseReq_q.base <= (cmdAddr_q >> `SFQ_BLOCK_BITS) << `SFQ_BLOCK_BITS;
                     eraseReq_q.block <= 1'b1;
                     timer_q <= 27'(BLK_CYC);
                  end else begin
                     eraseReq_q.base <= (cmdAddr_q >> `SFQ_SECT_BITS) << `SFQ_SECT_BITS;
                     eraseReq_q.block <= 1'b0;
                     timer_q <= 27'(SECT_CYC);
                  end
                  busySt_q <= sfq_pkg::B_WAIT;
               end else if (csRise && state_q == sfq_pkg::S_WEN) begin
                  weLatch_q <= 1'b1;
               end
            end
            sfq_pkg::B_DRAIN: begin
               // Stalls while the array back-pressures the FIFO
               if (!drainPush || fifoInReady) begin
                  scanIdx_q <= scanIdx_q + 8'h01;
                  if (scanIdx_q == 8'hff) begin
                     busySt_q <= sfq_pkg::B_WAIT;
                  end
               end
            end
            sfq_pkg::B_WAIT: begin
               if (timer_q != 27'h0) begin
                  timer_q <= timer_q - 27'h1;
               end else if (!memWrValid) begin
                  busy_q <= 1'b0;
                  busySt_q <= sfq_pkg::B_IDLE;
               end
            end
            default: begin
               busySt_q <= sfq_pkg::B_IDLE;
            end
         endcase
      end
   end

   sfq_fifo #(.WIDTH($bits(sfq_pkg::sfqProgWord_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(ref_clk),
      .rst(sys_rst),
      .inValid(drainPush),
      .inReady(fifoInReady),
      .inData(drainWord),
      .outValid(memWrValid),
      .outReady(memWrReady),
      .outData(memWr)
   );

   assign ioLineOut = ioOut_q;
   assign ioLineOe_n = ioOeN_q;
   assign writeEnableLatch = weLatch_q;
   assign writeInProgressFlag = busy_q;
   assign executeInPlace = contMode_q;
   assign memRdAddr = rdAddr_q;
   assign eraseStrobe = eraseStrobe_q;
   assign eraseReq = eraseReq_q;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // Serial clocks from address end to first data state
   logic [3:0] waitClks_q;
   always_ff @(posedge ref_clk) begin
      if (sys_rst || addrDone) begin
         waitClks_q <= 4'h0;
      end else if (sclkRise && csLow && (state_q == sfq_pkg::S_MODE || state_q == sfq_pkg::S_DUMMY)) begin
         waitClks_q <= waitClks_q + 4'h1;
      end
   end
   sequence lowNibOut;
      sclkFall && csLow && state_q == sfq_pkg::S_DATA && !nibHi_q;
   endsequence
   sequence startSeq;
      startProg || startErase;
   endsequence

   read_dummy_a: assert property ($rose(state_q == sfq_pkg::S_DATA) |-> waitClks_q == `SFQ_QREAD_WAIT)
      else $error("quad read dummy count wrong");
   nib_drive_a: assert property (sclkFall && csLow && state_q == sfq_pkg::S_DATA |=> ioOeN_q == 4'h0)
      else $error("data nibble not driven");
   addr_step_a: assert property (lowNibOut |=> rdAddr_q == (($past(rdAddr_q) + 32'h1) & ADDR_MASK))
      else $error("read address did not advance");
   cs_release_a: assert property (csRise |=> ioOeN_q == `SFQ_OE_OFF)
      else $error("lines still driven after deselect");
   cont_keep_a: assert property (csRise && rdCmd_q && modeSeen_q && modeInv |=> contMode_q)
      else $error("continuous mode not kept");
   cont_leave_a: assert property (csRise && rdCmd_q && modeSeen_q && !modeInv |=> !contMode_q)
      else $error("continuous mode not left");
   busy_reject_a: assert property (sclkRise && csLow && state_q == sfq_pkg::S_OPC && phaseEnd
      && shNext[7:0] == `SFQ_OP_QREAD && busy_q |=> state_q == sfq_pkg::S_IGN)
      else $error("read accepted while busy");
   latch_needed_a: assert property ($rose(busy_q) |-> $past(weLatch_q))
      else $error("cycle started without latch");
   prog_align_a: assert property (csRise && state_q == sfq_pkg::S_PDAT && cnt_q != 6'h00 && !busy_q |=> !busy_q)
      else $error("misaligned program executed");
   cycle_start_a: assert property (startSeq |=> busy_q && !weLatch_q ##1 busy_q)
      else $error("cycle start flags wrong");
   protect_a: assert property ($rose(busy_q) |-> !$past(protHit))
      else $error("protected region altered");
   erase_point_a: assert property ($rose(eraseStrobe_q) |-> $past(state_q) == sfq_pkg::S_EWAIT)
      else $error("erase at wrong select edge");
endmodule

// file: verilog/sfq_consts.svh
// Purpose: Constants of the quad read, program and erase sequencer.
// Assumes: Included by its bare name wherever the values are needed.
// Notes: Times are in microseconds and the clock rate in MHz.
`ifndef SFQ_CONSTS_SVH
`define SFQ_CONSTS_SVH
// Opcodes taken on the serial lines
`define SFQ_OP_QREAD 8'heb
`define SFQ_OP_PROG 8'h02
`define SFQ_OP_SECT 8'h20
`define SFQ_OP_BLOCK 8'hd8
`define SFQ_OP_WEN 8'h06
// Phase lengths, in bits or serial clocks
`define SFQ_BYTE_BITS 6'h08
`define SFQ_ADDR3_BITS 6'h18
`define SFQ_ADDR4_BITS 6'h20
`define SFQ_MODE_CLKS 6'h02
`define SFQ_DUMMY_CLKS 6'h04
`define SFQ_QREAD_WAIT 4'h6
// Region sizes as address bit counts
`define SFQ_PAGE_BITS 8
`define SFQ_SECT_BITS 12
`define SFQ_BLOCK_BITS 16
// Self-timed cycle lengths
`define SFQ_CLK_MHZ 250
`define SFQ_PROG_TIME_US 800
`define SFQ_SECT_TIME_US 50000
`define SFQ_BLK_TIME_US 400000
// Reset values
`define SFQ_PIN_RST 6'h02
`define SFQ_OE_OFF 4'hf
`endif

// file: verilog/sfq_pkg.sv
// Purpose: Types shared by the quad read, program and erase sequencer.
// Assumes: Used with full package names, never imported.
// Notes: Addresses are carried at 32 bits; unused top bits stay zero.
package sfq_pkg;
   // Serial protocol phases
   typedef enum {S_IDLE, S_OPC, S_ADDR, S_MODE, S_DUMMY, S_DATA, S_PDAT, S_EWAIT, S_WEN, S_IGN} sfqProto_t;
   // Self-timed cycle phases
   typedef enum {B_IDLE, B_DRAIN, B_WAIT} sfqBusy_t;
   // One byte to be programmed into the array
   typedef struct packed {
      logic [31:0] addr;
      logic [7:0] data;
   } sfqProgWord_t;
   // One erase request to the array
   typedef struct packed {
      logic [31:0] base;
      logic block;
   } sfqErase_t;
endpackage

// file: sim/sfq_host_model.sv
// Purpose: Host controller model on the serial pins of the flash front end.
// Assumes: Half a serial clock is 8 ref_clk cycles, moved on falling ref_clk.
// Notes: Clock idles low between frames; released lines toggle every clock.
`timescale 1ns/100ps
module sfq_host_model (
   input wire logic ref_clk,
   output logic sclkPin,
   output logic csPin_n,
   output logic [3:0] ioLineIn,
   input wire logic [3:0] ioLineOut
);
   initial begin
      sclkPin = 1'b0;
      csPin_n = 1'b1;
      ioLineIn = 4'h0;
   end
   // Half a serial clock; slow enough for the pin synchroniser
   task automatic half();
      repeat (8) @(negedge ref_clk);
   endtask
   // One clock: lines set while low, read data taken at the rise
   task automatic tick(input logic [3:0] v, output logic [3:0] g);
      ioLineIn = v;
      half();
      sclkPin = 1'b1;
      g = ioLineOut;
      half();
      sclkPin = 1'b0;
   endtask
   // Select stays low for the whole command
   task automatic sel();
      csPin_n = 1'b0;
      half();
   endtask
   // Send n bits MSB first, one or four a clock
   task automatic send(input logic [31:0] v, input int n, input bit quad);
      logic [3:0] g;
      for (int i = n; i > 0; i -= (quad ? 4 : 1))
         tick(quad ? v[i-1 -: 4] : {3'h0, v[i-1]}, g);
   endtask
   // Lines released: a toggling pattern so no stale value looks driven
   task automatic rel(input int n, output logic [31:0] got);
      logic [3:0] g;
      got = 32'h0;
      for (int i = 0; i < n; i++) begin
         tick(~ioLineIn, g);
         got = {got[27:0], g};
      end
   endtask
   // Deselect only on a clock boundary, then idle
   task automatic desel();
      half();
      csPin_n = 1'b1;
      repeat (16) @(negedge ref_clk);
   endtask
endmodule

// file: sim/tb.sv
// Purpose: Self-checking bench of the flash front end.
// Assumes: Short self-timed counts and a 24-bit array space.
// Notes: Array byte is address xor 3c; write port stalls every other cycle.
`timescale 1ns/100ps
module tb;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sclkPin, csPin_n, writeEnableLatch, writeInProgressFlag, executeInPlace, memWrValid, eraseStrobe;
   logic [3:0] ioLineIn, ioLineOut, ioLineOe_n;
   logic [3:0] blockProtectBits = 4'h0;
   logic fourByteMode = 1'b0;
   logic quadCommandMode = 1'b0;
   logic memWrReady = 1'b0;
   logic [7:0] memRdData = 8'h00;
   logic [31:0] memRdAddr, got, a;
   logic [7:0] m, op;
   logic x, ok;
   bit contExp = 1'b0;
   int n;
   int strobes = 0;
   int failures = 0;
   int samples_checked = 0;
   sfq_pkg::sfqProgWord_t memWr;
   sfq_pkg::sfqErase_t eraseReq;
   sfq_pkg::sfqProgWord_t wrLog[$];
   // Read rows: address, mode byte, four-byte mode, quad command mode
   localparam logic [41:0] RD [8] = '{{32'h10, 8'ha5, 2'b00}, {32'hfffffe, 8'h5a, 2'b00},
      {32'h1000, 8'hf0, 2'b00}, {32'h20, 8'h0f, 2'b00}, {32'h31, 8'hff, 2'b00},
      {32'h40, 8'h00, 2'b10}, {32'h50, 8'haa, 2'b01}, {32'h60, 8'h55, 2'b00}};
   // Erase rows: opcode, address, stray extra bit, protection code
   localparam logic [44:0] ER [4] = '{{8'h20, 32'h12345, 1'b0, 4'h0}, {8'hd8, 32'habcde, 1'b0, 4'h0},
      {8'h20, 32'h12345, 1'b1, 4'h0}, {8'hd8, 32'hff1234, 1'b0, 4'h1}};
   // Program words expected in page offset order
   localparam logic [39:0] PW [3] = '{{32'h400, 8'h33}, {32'h4fe, 8'h11}, {32'h4ff, 8'h22}};
   always #2 ref_clk = ~ref_clk;
   // Array model driven off the sampling edge
   always @(negedge ref_clk) begin
      memRdData <= memRdAddr[7:0] ^ 8'h3c;
      memWrReady <= ~memWrReady;
   end
   // Log accepted words and erase pulses
   always @(posedge ref_clk) begin
      if (memWrValid && memWrReady) wrLog.push_back(memWr);
      if (eraseStrobe) strobes++;
   end
   sfq_host_model i_sfq_host_model (.ref_clk(ref_clk), .sclkPin(sclkPin), .csPin_n(csPin_n),
      .ioLineIn(ioLineIn), .ioLineOut(ioLineOut));
   sfq_flash_seq #(.ADDR_W(24), .PROG_CYC(20), .SECT_CYC(40), .BLK_CYC(2000)) i_sfq_flash_seq (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .sclkPin(sclkPin), .csPin_n(csPin_n), .ioLineIn(ioLineIn),
      .ioLineOut(ioLineOut), .ioLineOe_n(ioLineOe_n), .fourByteMode(fourByteMode),
      .quadCommandMode(quadCommandMode), .blockProtectBits(blockProtectBits),
      .writeEnableLatch(writeEnableLatch), .writeInProgressFlag(writeInProgressFlag),
      .executeInPlace(executeInPlace), .memRdAddr(memRdAddr), .memRdData(memRdData),
      .memWrValid(memWrValid), .memWrReady(memWrReady), .memWr(memWr), .eraseStrobe(eraseStrobe),
      .eraseReq(eraseReq));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (failures == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Opcode on one line, or two nibbles in quad command mode
   task automatic opc(input logic [7:0] o);
      i_sfq_host_model.send({24'h0, o}, 8, quadCommandMode);
   endtask
   // Three or four address bytes
   task automatic adr(input logic [31:0] v, input bit quad);
      i_sfq_host_model.send(v, fourByteMode ? 32 : 24, quad);
   endtask
   task automatic wrEnable();
      i_sfq_host_model.sel();
      opc(8'h06);
      i_sfq_host_model.desel();
   endtask
   // Wait for the self-timed cycle, bounded
   task automatic idle();
      for (int i = 0; i < 3000 && writeInProgressFlag !== 1'b0; i++) @(negedge ref_clk);
      check(writeInProgressFlag, 1'b0);
   endtask
   // Quad read of three bytes; opcode skipped in continuous mode
   task automatic qread(input logic [31:0] v, input logic [7:0] md, input bit noOpc);
      logic [23:0] exp;
      i_sfq_host_model.sel();
      if (!noOpc) opc(8'heb);
      adr(v, 1'b1);
      i_sfq_host_model.send({24'h0, md}, 8, 1'b1);
      i_sfq_host_model.rel(4, got);
      i_sfq_host_model.rel(6, got);
      repeat (6) @(negedge ref_clk);
      for (int k = 0; k < 3; k++) exp = {exp[15:0], (v[7:0] + 8'(k)) ^ 8'h3c};
      check({got[23:0], ioLineOe_n, memRdAddr}, {exp, 4'h0, (v + 32'h3) & 32'hffffff});
      i_sfq_host_model.desel();
   endtask
   // Hang guard, well beyond the expected run
   initial begin
      #400000;
      failures++;
      final_report();
   end
   initial begin
      repeat (20) @(negedge ref_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      check({ioLineOe_n, writeEnableLatch, writeInProgressFlag, executeInPlace, eraseStrobe}, 8'hf0);
      for (int r = 0; r < 8; r++) begin
         {a, m, fourByteMode, quadCommandMode} = RD[r];
         qread(a, m, contExp);
         contExp = (m[7:4] == ~m[3:0]);
         check({executeInPlace, ioLineOe_n}, {contExp, 4'hf});
      end
      for (int r = 0; r < 4; r++) begin
         {op, a, x, blockProtectBits} = ER[r];
         ok = !x && blockProtectBits == 4'h0;
         n = strobes;
         wrEnable();
         check(writeEnableLatch, 1'b1);
         i_sfq_host_model.sel();
         opc(op);
         adr(a, 1'b0);
         if (x) i_sfq_host_model.send(32'h0, 1, 1'b0);
         i_sfq_host_model.desel();
         check({strobes - n, writeInProgressFlag, writeEnableLatch}, {32'(ok), ok, !ok});
         if (ok) check(eraseReq, {a & (op[7] ? 32'hffff0000 : 32'hfffff000), op[7]});
         // A read during a long erase must stay silent
         if (ok && op[7]) begin
            i_sfq_host_model.sel();
            opc(8'heb);
            adr(32'h0, 1'b1);
            i_sfq_host_model.rel(12, got);
            check({ioLineOe_n, writeInProgressFlag}, {4'hf, 1'b1});
            i_sfq_host_model.desel();
         end
         idle();
      end
      blockProtectBits = 4'h0;
      wrEnable();
      i_sfq_host_model.sel();
      opc(8'h02);
      adr(32'h4fe, 1'b0);
      i_sfq_host_model.send(32'h112233, 24, 1'b0);
      i_sfq_host_model.desel();
      idle();
      check(wrLog.size(), 3);
      foreach (PW[i]) check(wrLog[i], PW[i]);
      // Refused programs: no latch, ragged end, protected page
      for (int r = 0; r < 3; r++) begin
         if (r > 0) wrEnable();
         blockProtectBits = (r == 2) ? 4'h1 : 4'h0;
         i_sfq_host_model.sel();
         opc(8'h02);
         adr(r == 2 ? 32'hff0000 : 32'h100, 1'b0);
         i_sfq_host_model.send(32'h5a, r == 1 ? 12 : 8, 1'b0);
         i_sfq_host_model.desel();
         check({writeInProgressFlag, writeEnableLatch, memWrValid}, {1'b0, r > 0, 1'b0});
      end
      final_report();
   end
endmodule
